/* rtl/swc_pkg.sv */
`default_nettype none
package swc_pkg;

  localparam logic [11:0] SWC_CTL_OFF  = 12'h32C;
  localparam logic [31:0] SWC_RSV_MASK = 32'hFFF8_3E00;

  // Field positions
  localparam int BIT_FULL_RST   = 0;
  localparam int BIT_WARM_RST   = 1;
  localparam int BIT_HOLD       = 2;
  localparam int BIT_UNLOCK     = 3;
  localparam int BIT_BUDGET_UL  = 4;
  localparam int BIT_LDWR_DIS   = 5;
  localparam int BIT_SKIP_EE    = 6;
  localparam int BIT_STRICT     = 7;
  localparam int BIT_PEER_DIS   = 8;
  localparam int BIT_STORE_FWD  = 14;
  localparam int BIT_LOCK_BYP   = 15;
  localparam int BIT_WAKE_DIR   = 16;
  localparam int BIT_AUX_EN     = 17;
  localparam int BIT_VBC_DROP   = 18;

  // Reset values
  localparam logic RST_HOLD     = 1'b0;
  localparam logic RST_UNLOCK   = 1'b0;
  localparam logic RST_FIELD    = 1'b0;
  localparam logic RST_WAKE_DIR = 1'b0;

  // Cycles after power-on reset before the synced pin level is valid
  localparam logic [1:0] AUX_SYNC_WAIT = 2'h2;

  typedef struct packed {
    logic vendor_broadcast_drop;
    logic aux_power_use_enable;
    logic wake_pin_direction;
    logic lock_semantics_bypass;
    logic store_forward_force;
    logic peer_traffic_disable;
    logic strict_ordering_force;
    logic skip_eeprom_load_on_warm_reset;
    logic link_down_warm_reset_disable;
    logic budget_data_unlock;
    logic protected_field_unlock;
    logic hold_in_reset;
  } swc_ctl_t;

endpackage
`default_nettype wire

/* rtl/swc_switch_control.sv */
// Behaviour
// - Writing bit 0 one pulses full reset.
// - Writing bit 1 one pulses warm reset.
// - Hold bit keeps switch logic in reset.
// - EEPROM error sets the hold bit.
// - Unlock bit gates protected field writes.
// - Unlock set during reset operation.
// - Budget unlock opens power budget registers.
// - Bit 5 suppresses link-down warm resets.
// - Bit 6 skips EEPROM load on warm reset.
// - Bit 7 forces strict ordering.
// - Bit 8 blocks peer-to-peer traffic.
// - Bit 14 forces store-and-forward routing.
// - Bit 15 bypasses lock semantics.
// - Bit 16 sets wake pin direction.
// - Bit 17 loads inverse of disable pin.
// - Bit 18 drops vendor broadcasts.
`timescale 1ns/1ns
`default_nettype none
module swc_switch_control
  import swc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        fund_rst_i,
  input  wire logic        reset_seq_i,
  input  wire logic        eeprom_err_i,
  input  wire logic        hold_strap_i,
  input  wire logic        link_dl_down_i,
  input  wire logic        wake_req_i,
  input  wire logic        aux_power_disable_pin_i,
  input  wire logic        wake_pin_i,
  output logic             wake_pin_o,
  output logic             wake_pin_oe_o,
  output logic             wake_seen_o,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             full_reset_trigger_o,
  output logic             warm_reset_trigger_o,
  output logic             hold_in_reset_o,
  output logic             budget_wr_ok_o,
  output swc_ctl_t         ctl_o
);

  swc_ctl_t    ctl_q;
  swc_ctl_t    ctl_d;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        full_q;
  logic        warm_q;
  logic        aux_s1_q;
  logic        aux_s2_q;
  logic        wake_s1_q;
  logic        wake_s2_q;
  logic        hold_s1_q;
  logic        hold_s2_q;
  logic [1:0]  aux_cnt_q;
  logic        aux_load_q;

  wire         req      = wb_cyc_i & wb_stb_i;
  wire         hit      = wb_adr_i[11:2] == SWC_CTL_OFF[11:2];
  wire         commit   = req & ack_q & wb_we_i & hit;
  wire         wr_l0    = commit & wb_sel_i[0];
  wire         wr_l1    = commit & wb_sel_i[1];
  wire         wr_l2    = commit & wb_sel_i[2];
  wire         unlocked = ctl_q.protected_field_unlock;
  wire [31:0]  rd_word;

  assign rd_word = {13'h0,
                    ctl_q.vendor_broadcast_drop,
                    ctl_q.aux_power_use_enable,
                    ctl_q.wake_pin_direction,
                    ctl_q.lock_semantics_bypass,
                    ctl_q.store_forward_force,
                    5'h0,
                    ctl_q.peer_traffic_disable,
                    ctl_q.strict_ordering_force,
                    ctl_q.skip_eeprom_load_on_warm_reset,
                    ctl_q.link_down_warm_reset_disable,
                    ctl_q.budget_data_unlock,
                    ctl_q.protected_field_unlock,
                    ctl_q.hold_in_reset,
                    2'h0};

  always_comb
  begin
    ctl_d = ctl_q;
    if (wr_l0)
    begin
      ctl_d.hold_in_reset                  = wb_dat_i[BIT_HOLD];
      ctl_d.protected_field_unlock         = wb_dat_i[BIT_UNLOCK];
      if (unlocked)
      begin
        ctl_d.budget_data_unlock = wb_dat_i[BIT_BUDGET_UL];
      end
      ctl_d.link_down_warm_reset_disable   = wb_dat_i[BIT_LDWR_DIS];
      ctl_d.skip_eeprom_load_on_warm_reset = wb_dat_i[BIT_SKIP_EE];
      ctl_d.strict_ordering_force          = wb_dat_i[BIT_STRICT];
    end
    if (wr_l1)
    begin
      ctl_d.peer_traffic_disable  = wb_dat_i[BIT_PEER_DIS];
      ctl_d.store_forward_force   = wb_dat_i[BIT_STORE_FWD];
      ctl_d.lock_semantics_bypass = wb_dat_i[BIT_LOCK_BYP];
    end
    if (wr_l2)
    begin
      ctl_d.wake_pin_direction    = wb_dat_i[BIT_WAKE_DIR];
      ctl_d.aux_power_use_enable  = wb_dat_i[BIT_AUX_EN];
      ctl_d.vendor_broadcast_drop = wb_dat_i[BIT_VBC_DROP];
    end
    if (eeprom_err_i)
    begin
      ctl_d.hold_in_reset = 1'b1;
    end
    if (reset_seq_i)
    begin
      ctl_d.protected_field_unlock = 1'b1;
    end
    if (aux_load_q)
    begin
      ctl_d.aux_power_use_enable = ~aux_s2_q;
    end
    // Full reset spares wake and aux bits; hold strap wins over writes
    if (fund_rst_i)
    begin
      ctl_d.hold_in_reset                  = hold_s2_q;
      ctl_d.protected_field_unlock         = reset_seq_i;
      ctl_d.budget_data_unlock             = RST_FIELD;
      ctl_d.link_down_warm_reset_disable   = RST_FIELD;
      ctl_d.skip_eeprom_load_on_warm_reset = RST_FIELD;
      ctl_d.strict_ordering_force          = RST_FIELD;
      ctl_d.peer_traffic_disable           = RST_FIELD;
      ctl_d.store_forward_force            = RST_FIELD;
      ctl_d.lock_semantics_bypass          = RST_FIELD;
      ctl_d.vendor_broadcast_drop          = RST_FIELD;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctl_q <= '0;
      ctl_q.hold_in_reset <= RST_HOLD;
      ctl_q.protected_field_unlock <= RST_UNLOCK;
      ctl_q.wake_pin_direction <= RST_WAKE_DIR;
    end
    else
    begin
      ctl_q <= ctl_d;
    end
  end

  // Pin synchronisers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aux_s1_q  <= 1'b0;
      aux_s2_q  <= 1'b0;
      // Idle level of the pin, so no false wake after reset
      wake_s1_q <= 1'b1;
      wake_s2_q <= 1'b1;
      hold_s1_q <= 1'b0;
      hold_s2_q <= 1'b0;
    end
    else
    begin
      aux_s1_q  <= aux_power_disable_pin_i;
      aux_s2_q  <= aux_s1_q;
      wake_s1_q <= wake_pin_i;
      wake_s2_q <= wake_s1_q;
      hold_s1_q <= hold_strap_i;
      hold_s2_q <= hold_s1_q;
    end
  end

  // Pin level only valid once the synchroniser has filled
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aux_cnt_q  <= 2'h0;
      aux_load_q <= 1'b0;
    end
    else
    begin
      aux_load_q <= aux_cnt_q == AUX_SYNC_WAIT - 2'h1;
      if (aux_cnt_q != AUX_SYNC_WAIT)
      begin
        aux_cnt_q <= aux_cnt_q + 2'h1;
      end
    end
  end

  // Bus slave, one wait state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      dat_q <= (req & ~ack_q & hit) ? rd_word : 32'h0000_0000;
    end
  end

  // Trigger pulses
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      full_q <= 1'b0;
      warm_q <= 1'b0;
    end
    else
    begin
      full_q <= wr_l0 & wb_dat_i[BIT_FULL_RST];
      warm_q <= (wr_l0 & wb_dat_i[BIT_WARM_RST]) |
                (link_dl_down_i & ~ctl_q.link_down_warm_reset_disable);
    end
  end

  assign wb_ack_o             = ack_q;
  assign wb_dat_o             = dat_q;
  assign full_reset_trigger_o = full_q;
  assign warm_reset_trigger_o = warm_q;
  assign hold_in_reset_o      = ctl_q.hold_in_reset;
  assign budget_wr_ok_o       = ctl_q.budget_data_unlock;
  assign ctl_o                = ctl_q;
  assign wake_pin_o           = 1'b0;
  assign wake_pin_oe_o        = ctl_q.wake_pin_direction & wake_req_i;
  assign wake_seen_o          = ~ctl_q.wake_pin_direction & ~wake_s2_q;

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_ack_follows;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("request not acked");

  property p_rsv_zero;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> ((wb_dat_o & (SWC_RSV_MASK | 32'h0000_0003)) == 32'h0000_0000);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved or trigger bit read one");

  property p_full_pulse;
    @(posedge clk_i) disable iff (rst_i)
    (commit && wb_sel_i[0] && wb_dat_i[0]) |=> full_reset_trigger_o ##1 !full_reset_trigger_o;
  endproperty
  a_full_pulse: assert property (p_full_pulse) else $error("full reset pulse wrong");

  property p_warm_gate;
    @(posedge clk_i) disable iff (rst_i || fund_rst_i)
    (link_dl_down_i && ctl_q.link_down_warm_reset_disable && !commit)
      |=> !warm_reset_trigger_o;
  endproperty
  a_warm_gate: assert property (p_warm_gate) else $error("link-down warm reset not gated");

  property p_err_hold;
    @(posedge clk_i) disable iff (rst_i || fund_rst_i)
    eeprom_err_i |=> hold_in_reset_o;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("eeprom error did not hold");

  property p_lock_guard;
    @(posedge clk_i) disable iff (rst_i || fund_rst_i)
    (!unlocked && !reset_seq_i) |=> $stable(ctl_q.budget_data_unlock);
  endproperty
  a_lock_guard: assert property (p_lock_guard) else $error("locked field changed");

  property p_seq_unlock;
    @(posedge clk_i) disable iff (rst_i)
    reset_seq_i |=> ctl_q.protected_field_unlock;
  endproperty
  a_seq_unlock: assert property (p_seq_unlock) else $error("unlock not set in reset");

  property p_aux_load;
    @(posedge clk_i) disable iff (rst_i)
    aux_load_q |=> (ctl_q.aux_power_use_enable == !$past(aux_s2_q));
  endproperty
  a_aux_load: assert property (p_aux_load) else $error("aux enable not pin inverse");

  property p_wake_dir;
    @(posedge clk_i)
    $fell(rst_i) |-> !ctl_q.wake_pin_direction && !wake_pin_oe_o;
  endproperty
  a_wake_dir: assert property (p_wake_dir) else $error("wake not input after reset");

endmodule
`default_nettype wire

/* verification/tb_swc_switch_control.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_swc_switch_control;
  import swc_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  ev = 4'h0;
  logic        wreq = 1'b0;
  logic        wpin = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, full_t, warm_t, hold_o, bud_o, oe, pin_o, seen;
  swc_ctl_t    ctl;
  int          err_total = 0;
  int          comparisons = 0;
  int          ticks = 0;

  always #10 clk_i = ~clk_i;

  swc_switch_control swc_switch_control_inst (
    .clk_i(clk_i), .rst_i(rst_i), .fund_rst_i(ev[0]), .reset_seq_i(ev[1]),
    .eeprom_err_i(ev[2]), .hold_strap_i(1'b1), .link_dl_down_i(ev[3]),
    .wake_req_i(wreq), .aux_power_disable_pin_i(1'b0), .wake_pin_i(wpin),
    .wake_pin_o(pin_o), .wake_pin_oe_o(oe), .wake_seen_o(seen),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .full_reset_trigger_o(full_t), .warm_reset_trigger_o(warm_t),
    .hold_in_reset_o(hold_o), .budget_wr_ok_o(bud_o), .ctl_o(ctl));

  task give_verdict;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Classic cycle, held until ack; pulses land before return
  task bus(input logic w, input logic [11:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) chk("ack", 32'h1, 32'h0);
    #1;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 4'hF, 32'h0);
    chk("read data", exp, q);
  endtask

  // One-cycle event pulse; registered effect seen after
  task kick(input logic [3:0] v);
    @(posedge clk_i);
    ev <= v;
    @(posedge clk_i);
    ev <= 4'h0;
    #1;
  endtask

  always @(posedge clk_i)
  begin
    ticks++;
    if (ticks == 3000)
    begin
      err_total++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(SWC_CTL_OFF, 32'h0002_0000);
    $display("test 1 done");
    bus(1'b1, SWC_CTL_OFF, 4'hF, 32'hFFFF_FFFF);
    chk("full trigger", 32'h1, {31'h0, full_t});
    chk("warm trigger", 32'h1, {31'h0, warm_t});
    chk("hold level", 32'h1, {31'h0, hold_o});
    rd(SWC_CTL_OFF, 32'h0007_C1EC);
    bus(1'b1, SWC_CTL_OFF, 4'hF, 32'hFFFF_FFFF);
    rd(SWC_CTL_OFF, 32'h0007_C1FC);
    chk("budget unlock", 32'h1, {31'h0, bud_o});
    chk("steering set", 32'h0000_0FFF, {20'h0, ctl});
    chk("wake idle", 32'h0, {31'h0, seen});
    @(posedge clk_i);
    wreq <= 1'b1;
    #1 chk("wake enable", 32'h1, {31'h0, oe});
    kick(4'h8);
    chk("masked link down", 32'h0, {31'h0, warm_t});
    $display("test 2 done");
    bus(1'b1, SWC_CTL_OFF, 4'hF, 32'h0000_0000);
    chk("full on zero", 32'h0, {31'h0, full_t});
    chk("warm on zero", 32'h0, {31'h0, warm_t});
    chk("wake enable off", 32'h0, {31'h0, oe});
    chk("wake drive level", 32'h0, {31'h0, pin_o});
    chk("steering clear", 32'h0, {20'h0, ctl});
    chk("wake idle input", 32'h0, {31'h0, seen});
    @(posedge clk_i);
    wpin <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1 chk("wake seen", 32'h1, {31'h0, seen});
    @(posedge clk_i);
    wpin <= 1'b1;
    rd(SWC_CTL_OFF, 32'h0000_0000);
    kick(4'h8);
    chk("link down", 32'h1, {31'h0, warm_t});
    $display("test 3 done");
    kick(4'h4);
    rd(SWC_CTL_OFF, 32'h0000_0004);
    kick(4'h2);
    rd(SWC_CTL_OFF, 32'h0000_000C);
    // Byte lane two only: low byte must survive
    bus(1'b1, SWC_CTL_OFF, 4'h4, 32'h0003_0000);
    rd(SWC_CTL_OFF, 32'h0003_000C);
    kick(4'h1);
    rd(SWC_CTL_OFF, 32'h0003_0004);
    $display("test 4 done");
    rd(12'h330, 32'h0000_0000);
    bus(1'b1, 12'h330, 4'hF, 32'hFFFF_FFFF);
    rd(SWC_CTL_OFF, 32'h0003_0004);
    $display("test 5 done");
    give_verdict();
  end
endmodule
`default_nettype wire
